// File: common/dslas_pkg.sv
`default_nettype none
package dslas_pkg;
	// register offsets on the 4-bit register port
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_CONFIG = 4'h1;
	localparam logic [3:0] ADDR_SUBSTATE = 4'h5;
	localparam logic [3:0] ADDR_MAJOR = 4'h6;
	// control register fields
	localparam int CTRL_REQUEST_BIT = 0;
	localparam int CTRL_QUIET_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	// config register fields
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_TSEL_LSB = 3;
	localparam logic [2:0] MODE_RESET = 3'h7;
	localparam logic [1:0] TSEL_RESET = 2'h0;
	// major state status fields
	localparam int MAJ_EXPIRED_BIT = 4;
	// operating modes
	localparam logic [2:0] MODE_TRANSP_SIGN = 3'h0;
	localparam logic [2:0] MODE_TRANSP_MAG = 3'h1;
	localparam logic [2:0] MODE_TRANSP_SCR = 3'h2;
	localparam logic [2:0] MODE_RESERVED = 3'h3;
	localparam logic [2:0] MODE_INDEP_SIGN = 3'h4;
	localparam logic [2:0] MODE_INDEP_SCR = 3'h5;
	localparam logic [2:0] MODE_FRAMED_E1 = 3'h6;
	localparam logic [2:0] MODE_FRAMED_T1 = 3'h7;
	// timers count frames
	localparam int TMR_W = 13;
	localparam logic [12:0] MATC_LONG = 13'h1388;
	localparam logic [12:0] MATC_MID = 13'h09c4;
	localparam logic [12:0] MATC_SHORT = 13'h0683;
	localparam logic [12:0] M_SUBSTATE_TIMER_FIRST = 13'h000a;
	localparam logic [12:0] M_SUBSTATE_TIMER_SECOND = 13'h0013;
	localparam logic [12:0] M_SUBSTATE_TIMER_THIRD = 13'h0041;
	localparam logic [12:0] M_SUBSTATE_TIMER_FOURTH = 13'h004e;
	localparam logic [12:0] M_SUBSTATE_TIMER_FIFTH = 13'h0067;
	localparam logic [12:0] S_SUBSTATE_TIMER_FIRST = 13'h001b;
	localparam logic [12:0] S_SUBSTATE_TIMER_SECOND = 13'h0013;
	localparam logic [12:0] S_SUBSTATE_TIMER_THIRD = 13'h0027;
	localparam logic [12:0] S_SUBSTATE_TIMER_FOURTH = 13'h004e;
	localparam logic [12:0] S_SUBSTATE_TIMER_FIFTH = 13'h0040;
	localparam logic [1:0] FSW_HITS_NEEDED = 2'h2;
	// scrambler taps, 23-stage
	localparam int SCR_LEN = 23;
	localparam int SCR_TAP_A = 17;
	localparam int SCR_TAP_B = 22;
	localparam logic [22:0] SCR_SEED = 23'h7f_ffff;

	typedef enum logic [2:0] {
		MAJ_INACTIVE, MAJ_ACTIVATING, MAJ_ACTIVE1, MAJ_ACTIVE2, MAJ_DEACTIVATED
	} dslas_major_e;
	typedef enum logic [3:0] {
		PH_IDLE, PH_1, PH_2, PH_3, PH_4, PH_5, PH_6, PH_LEVEL4, PH_FRAME
	} dslas_phase_e;
	typedef enum logic [1:0] {TX_NONE, TX_TWO, TX_FOUR, TX_DATA} dslas_tx_e;
endpackage
`default_nettype wire

// File: logic/dslas_act_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dslas_act_timer (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_clear,
	input wire logic i_load,
	input wire logic [12:0] i_load_val,
	input wire logic i_tick,
	input wire logic [12:0] i_limit,
	output logic [12:0] o_count,
	output logic o_expired
);
	typedef struct packed {
		logic [12:0] count;
		logic expired;
	} dslas_tmr_s;
	dslas_tmr_s q, d;

	always_comb begin
		d = q;
		if (i_clear) begin
			d.count = '0;
			d.expired = 1'b0;
		end else if (i_load) begin
			d.count = i_load_val;
		end else if (i_tick && !q.expired) begin
			d.count = q.count + 13'h0001;
			// sticky until the next start so late ticks cannot revive it
			if (d.count >= i_limit)
				d.expired = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst)
			q <= '0;
		else
			q <= d;
	end

	assign o_count = q.count;
	assign o_expired = q.expired;
endmodule
`default_nettype wire

// File: logic/dslas_tx_symbol.sv
`timescale 1ns/1ps
`default_nettype none
module dslas_tx_symbol (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_symbol_tick,
	input wire dslas_pkg::dslas_tx_e i_kind,
	input wire logic [2:0] i_mode,
	input wire logic i_sync_slot,
	input wire logic i_data_sign,
	input wire logic i_data_mag,
	output logic o_tx_enable,
	output logic o_tx_sign,
	output logic o_tx_mag
);
	typedef struct packed {
		logic [22:0] scr;
		logic en;
		logic sign;
		logic mag;
	} dslas_txs_s;
	dslas_txs_s q, d;
	logic framed, bypass, in_s, in_m, scr_s, scr_m;
	logic [22:0] s1;

	always_comb begin
		d = q;
		framed = (i_mode == dslas_pkg::MODE_FRAMED_E1) || (i_mode == dslas_pkg::MODE_FRAMED_T1);
		bypass = (i_mode == dslas_pkg::MODE_TRANSP_SIGN) || (i_mode == dslas_pkg::MODE_TRANSP_MAG)
			|| (i_mode == dslas_pkg::MODE_INDEP_SIGN) || (i_mode == dslas_pkg::MODE_RESERVED);
		in_s = i_data_sign;
		in_m = i_data_mag;
		if (i_kind == dslas_pkg::TX_TWO || (i_kind == dslas_pkg::TX_FOUR && framed)) begin
			in_s = 1'b1;
			in_m = 1'b1;
		end
		scr_s = in_s ^ q.scr[dslas_pkg::SCR_TAP_A] ^ q.scr[dslas_pkg::SCR_TAP_B];
		s1 = {q.scr[21:0], scr_s};
		scr_m = in_m ^ s1[dslas_pkg::SCR_TAP_A] ^ s1[dslas_pkg::SCR_TAP_B];
		if (i_symbol_tick) begin
			d.en = (i_kind != dslas_pkg::TX_NONE);
			// sync-slot symbols in framed modes skip the scrambler
			if (framed && i_sync_slot && i_kind != dslas_pkg::TX_NONE) begin
				d.sign = i_data_sign;
				// sync symbols of two-level training stay at +3/-3
				d.mag = (i_kind == dslas_pkg::TX_TWO) ? 1'b0 : i_data_mag;
			end else begin
				d.scr = {s1[21:0], scr_m};
				unique case (i_kind)
					dslas_pkg::TX_NONE: begin
						d.sign = 1'b0;
						d.mag = 1'b0;
					end
					// two-level keeps magnitude zero, so only +3/-3
					dslas_pkg::TX_TWO: begin
						d.sign = scr_s;
						d.mag = 1'b0;
					end
					dslas_pkg::TX_FOUR: begin
						d.sign = scr_s;
						d.mag = scr_m;
					end
					dslas_pkg::TX_DATA: begin
						d.sign = bypass ? i_data_sign : scr_s;
						d.mag = bypass ? i_data_mag : scr_m;
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			q.scr <= dslas_pkg::SCR_SEED;
			q.en <= 1'b0;
			q.sign <= 1'b0;
			q.mag <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign o_tx_enable = q.en;
	assign o_tx_sign = q.sign;
	assign o_tx_mag = q.mag;
endmodule
`default_nettype wire

// File: logic/dslas_sequencer.sv
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module dslas_sequencer (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_hw_mode,
	input wire logic i_master,
	input wire logic i_link_up_request,
	input wire logic i_quiet,
	input wire logic i_frame_tick,
	input wire logic i_symbol_tick,
	input wire logic i_sync_slot,
	input wire logic i_signal_absent,
	input wire logic i_four_level_detect,
	input wire logic i_frame_sync_word,
	input wire logic i_tx_data_sign,
	input wire logic i_tx_data_mag,
	input wire logic i_rx_data,
	output logic o_rx_data,
	output logic o_tx_enable,
	output logic o_tx_sign,
	output logic o_tx_mag,
	output logic o_activating,
	output logic o_active,
	output logic o_deactivated,
	output logic o_timer_expired,
	output logic [2:0] o_major_state_code,
	output logic [3:0] o_activating_substate_status
);
	typedef struct packed {
		dslas_pkg::dslas_major_e major;
		dslas_pkg::dslas_phase_e phase;
		logic req_bit;
		logic quiet_bit;
		logic [2:0] mode;
		logic [1:0] tsel;
		logic pin_prev;
		logic [1:0] fsw_hits;
		logic rx_data;
		logic [7:0] rdata;
	} dslas_seq_s;
	dslas_seq_s q, d;

	logic [12:0] tmr_count;
	logic tmr_expired;
	logic tmr_clear;
	logic tmr_load;
	logic [12:0] mat_limit;
	logic framed;
	logic request;
	logic quiet;
	logic phase_done;
	logic [3:0] sub_code;
	dslas_pkg::dslas_tx_e tx_kind;
	logic lost_signal;
	localparam logic [1:0] FSW_MAX = dslas_pkg::FSW_HITS_NEEDED;

	// end count of a timer-driven phase for the current role
	function automatic logic [12:0] phase_limit(input logic master,
			input dslas_pkg::dslas_phase_e ph);
		logic [12:0] lim;
		if (master) begin
			unique case (ph)
				dslas_pkg::PH_1: lim = dslas_pkg::M_SUBSTATE_TIMER_FIRST;
				dslas_pkg::PH_2: lim = dslas_pkg::M_SUBSTATE_TIMER_SECOND;
				dslas_pkg::PH_4: lim = dslas_pkg::M_SUBSTATE_TIMER_THIRD;
				dslas_pkg::PH_5: lim = dslas_pkg::M_SUBSTATE_TIMER_FOURTH;
				dslas_pkg::PH_6: lim = dslas_pkg::M_SUBSTATE_TIMER_FIFTH;
				default: lim = '1;
			endcase
		end else begin
			unique case (ph)
				dslas_pkg::PH_1: lim = dslas_pkg::S_SUBSTATE_TIMER_SECOND;
				dslas_pkg::PH_2: lim = dslas_pkg::S_SUBSTATE_TIMER_FIRST;
				dslas_pkg::PH_3: lim = dslas_pkg::S_SUBSTATE_TIMER_THIRD;
				dslas_pkg::PH_4: lim = dslas_pkg::S_SUBSTATE_TIMER_FIFTH;
				dslas_pkg::PH_5: lim = dslas_pkg::S_SUBSTATE_TIMER_FOURTH;
				dslas_pkg::PH_6: lim = '0;
				default: lim = '1;
			endcase
		end
		return lim;
	endfunction

	always_comb begin
		framed = (q.mode == dslas_pkg::MODE_FRAMED_E1) || (q.mode == dslas_pkg::MODE_FRAMED_T1);
		unique case (q.tsel)
			2'h1: mat_limit = dslas_pkg::MATC_MID;
			2'h2: mat_limit = dslas_pkg::MATC_SHORT;
			default: mat_limit = dslas_pkg::MATC_LONG;
		endcase
		// edge on the pin, level on the register bit
		if (i_hw_mode) begin
			request = i_link_up_request && !q.pin_prev;
			quiet = i_quiet;
		end else begin
			request = q.req_bit;
			quiet = q.quiet_bit;
		end
		phase_done = tmr_count >= phase_limit(i_master, q.phase);
	end

	// substate code derived from one phase and role, major state separate
	always_comb begin
		sub_code = 4'h0;
		if (q.major == dslas_pkg::MAJ_ACTIVATING) begin
			unique case (q.phase)
				dslas_pkg::PH_1: sub_code = 4'h1;
				dslas_pkg::PH_2: sub_code = 4'h2;
				dslas_pkg::PH_3: sub_code = 4'h3;
				dslas_pkg::PH_4: sub_code = 4'h4;
				dslas_pkg::PH_5: sub_code = 4'h5;
				dslas_pkg::PH_6: sub_code = 4'h6;
				// master four-level 7, search 8; slave search 7
				dslas_pkg::PH_LEVEL4: sub_code = i_master ? 4'h7 : 4'h6;
				dslas_pkg::PH_FRAME: sub_code = i_master ? 4'h8 : 4'h7;
				default: sub_code = 4'h0;
			endcase
		end
	end

	// transmit signal for each phase
	always_comb begin
		tx_kind = dslas_pkg::TX_NONE;
		unique case (q.major)
			dslas_pkg::MAJ_ACTIVATING: begin
				// four-level from master code 7 or search; slave 1 silent
				if (q.phase == dslas_pkg::PH_FRAME
					|| (i_master && q.phase == dslas_pkg::PH_LEVEL4))
					tx_kind = dslas_pkg::TX_FOUR;
				else if (i_master || q.phase != dslas_pkg::PH_1)
					tx_kind = dslas_pkg::TX_TWO;
			end
			dslas_pkg::MAJ_ACTIVE1,
			dslas_pkg::MAJ_ACTIVE2: tx_kind = dslas_pkg::TX_DATA;
			dslas_pkg::MAJ_INACTIVE,
			dslas_pkg::MAJ_DEACTIVATED: tx_kind = dslas_pkg::TX_NONE;
		endcase
	end

	always_comb begin
		d = q;
		tmr_clear = 1'b0;
		tmr_load = 1'b0;
		d.pin_prev = i_link_up_request;
		d.rdata = 8'h00;

		if (i_wr) begin
			unique case (i_addr)
				dslas_pkg::ADDR_CONTROL: begin
					d.req_bit = i_wdata[dslas_pkg::CTRL_REQUEST_BIT];
					d.quiet_bit = i_wdata[dslas_pkg::CTRL_QUIET_BIT];
				end
				dslas_pkg::ADDR_CONFIG: begin
					d.mode = i_wdata[dslas_pkg::CFG_MODE_LSB +: 3];
					d.tsel = i_wdata[dslas_pkg::CFG_TSEL_LSB +: 2];
				end
				default: ;
			endcase
		end
		if (i_rd) begin
			unique case (i_addr)
				dslas_pkg::ADDR_CONTROL: d.rdata = {6'h00, q.quiet_bit, q.req_bit};
				dslas_pkg::ADDR_CONFIG: d.rdata = {3'h0, q.tsel, q.mode};
				dslas_pkg::ADDR_SUBSTATE: d.rdata = {4'h0, sub_code};
				dslas_pkg::ADDR_MAJOR: d.rdata = {3'h0, tmr_expired, 1'b0, 3'(q.major)};
				default: d.rdata = 8'h00;
			endcase
		end

		// two clean frames in a row are needed, a miss restarts the count
		if (q.phase == dslas_pkg::PH_FRAME && i_frame_tick) begin
			if (!i_frame_sync_word)
				d.fsw_hits = 2'h0;
			else if (q.fsw_hits != FSW_MAX)
				d.fsw_hits = q.fsw_hits + 2'h1;
		end

		unique case (q.major)
			dslas_pkg::MAJ_INACTIVE: begin
				// hold the timer at zero while idle
				tmr_clear = 1'b1;
				d.phase = dslas_pkg::PH_IDLE;
				// master starts on request, slave on line energy
				if (i_master) begin
					if (request && !quiet) begin
						d.major = dslas_pkg::MAJ_ACTIVATING;
						d.phase = dslas_pkg::PH_1;
					end
				end else if (!i_signal_absent) begin
					// slave leaves only when signal present
					d.major = dslas_pkg::MAJ_ACTIVATING;
					d.phase = dslas_pkg::PH_1;
				end
			end
			dslas_pkg::MAJ_ACTIVATING: begin
				// timeout or lost signal aborts before any phase step
				if (tmr_expired || lost_signal) begin
					d.major = dslas_pkg::MAJ_DEACTIVATED;
					d.phase = dslas_pkg::PH_IDLE;
				end else begin
					unique case (q.phase)
						dslas_pkg::PH_1, dslas_pkg::PH_2, dslas_pkg::PH_4,
						dslas_pkg::PH_5, dslas_pkg::PH_6: begin
							// timer ends the phase, slave 6 at once
							if (phase_done)
								d.phase = dslas_pkg::dslas_phase_e'(q.phase + 4'h1);
						end
						dslas_pkg::PH_3: begin
							if (i_master) begin
								if (!i_signal_absent) begin
									tmr_load = 1'b1;
									d.phase = dslas_pkg::PH_4;
								end
							end else if (phase_done) begin
								d.phase = dslas_pkg::PH_4;
							end
						end
						dslas_pkg::PH_LEVEL4: begin
							if (i_four_level_detect) begin
								if (framed) begin
									d.phase = dslas_pkg::PH_FRAME;
									d.fsw_hits = 2'h0;
								end else begin
									d.major = dslas_pkg::MAJ_ACTIVE1;
									d.phase = dslas_pkg::PH_IDLE;
								end
							end
						end
						dslas_pkg::PH_FRAME: begin
							if (q.fsw_hits == FSW_MAX) begin
								d.major = dslas_pkg::MAJ_ACTIVE1;
								d.phase = dslas_pkg::PH_IDLE;
							end
						end
						default: begin
							d.major = dslas_pkg::MAJ_DEACTIVATED;
							d.phase = dslas_pkg::PH_IDLE;
						end
					endcase
				end
			end
			dslas_pkg::MAJ_ACTIVE1: begin
				if (tmr_expired)
					d.major = dslas_pkg::MAJ_ACTIVE2;
			end
			dslas_pkg::MAJ_ACTIVE2: ;
			dslas_pkg::MAJ_DEACTIVATED: begin
				// master waits for the host to drop the level request
				if (i_master ? !(i_hw_mode ? i_link_up_request : q.req_bit) : i_signal_absent) begin
					d.major = dslas_pkg::MAJ_INACTIVE;
					d.phase = dslas_pkg::PH_IDLE;
				end
			end
		endcase

		if (d.major == dslas_pkg::MAJ_ACTIVE1 || d.major == dslas_pkg::MAJ_ACTIVE2)
			d.rx_data = i_rx_data;
		else
			d.rx_data = 1'b1;
	end

	// signal loss counts once the far end was heard
	assign lost_signal = i_signal_absent && !(i_master
		? (q.phase == dslas_pkg::PH_1 || q.phase == dslas_pkg::PH_2 || q.phase == dslas_pkg::PH_3)
		: 1'b0);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			q.major <= dslas_pkg::MAJ_INACTIVE;
			q.phase <= dslas_pkg::PH_IDLE;
			q.req_bit <= dslas_pkg::CTRL_RESET[dslas_pkg::CTRL_REQUEST_BIT];
			q.quiet_bit <= dslas_pkg::CTRL_RESET[dslas_pkg::CTRL_QUIET_BIT];
			q.mode <= dslas_pkg::MODE_RESET;
			q.tsel <= dslas_pkg::TSEL_RESET;
			q.pin_prev <= 1'b1;
			q.fsw_hits <= 2'h0;
			q.rx_data <= 1'b1;
			q.rdata <= 8'h00;
		end else begin
			q <= d;
		end
	end

	dslas_act_timer u_timer (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_clear(tmr_clear),
		.i_load(tmr_load),
		.i_load_val(dslas_pkg::M_SUBSTATE_TIMER_SECOND + 13'h0001),
		.i_tick(i_frame_tick),
		.i_limit(mat_limit),
		.o_count(tmr_count),
		.o_expired(tmr_expired)
	);

	dslas_tx_symbol u_tx (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_symbol_tick(i_symbol_tick),
		.i_kind(tx_kind),
		.i_mode(q.mode),
		.i_sync_slot(i_sync_slot),
		.i_data_sign(i_tx_data_sign),
		.i_data_mag(i_tx_data_mag),
		.o_tx_enable(o_tx_enable),
		.o_tx_sign(o_tx_sign),
		.o_tx_mag(o_tx_mag)
	);

	assign o_rdata = q.rdata;
	assign o_rx_data = q.rx_data;
	assign o_activating = (q.major == dslas_pkg::MAJ_ACTIVATING);
	assign o_active = (q.major == dslas_pkg::MAJ_ACTIVE1) || (q.major == dslas_pkg::MAJ_ACTIVE2);
	assign o_deactivated = (q.major == dslas_pkg::MAJ_DEACTIVATED);
	assign o_timer_expired = tmr_expired;
	assign o_major_state_code = 3'(q.major);
	assign o_activating_substate_status = sub_code;
endmodule
`default_nettype wire

// File: tb/dslas_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
module dslas_remote_model (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_tx_enable,
	input wire logic i_tx_mag,
	input wire logic i_respond,
	input wire logic i_fsw_ok,
	output logic o_frame_tick,
	output logic o_symbol_tick,
	output logic o_sync_slot,
	output logic o_signal_absent,
	output logic o_four_level_detect,
	output logic o_frame_sync_word,
	output logic o_rx_data
);
	logic [2:0] cnt_q;
	logic heard_q;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt_q <= 3'h0;
			heard_q <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 3'h1;
			heard_q <= heard_q | (i_tx_enable & i_tx_mag);
		end
	end
	// eight cycles a frame keeps the frame timers short in simulation
	assign o_frame_tick = (cnt_q == 3'h7);
	assign o_symbol_tick = cnt_q[0];
	assign o_sync_slot = (cnt_q[2:1] == 2'h0);
	assign o_signal_absent = !i_respond;
	assign o_four_level_detect = i_respond & heard_q;
	assign o_frame_sync_word = i_fsw_ok & o_frame_tick;
	// changes on six of every eight cycles so a stale value soon shows up as wrong data
	assign o_rx_data = cnt_q[0] ^ cnt_q[2];
endmodule
`default_nettype wire

// File: tb/dslas_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dslas_seq_checker (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [3:0] i_addr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic i_hw_mode,
	input wire logic i_master,
	input wire logic i_link_up_request,
	input wire logic i_quiet,
	input wire logic i_signal_absent,
	input wire logic i_rx_data,
	input wire logic o_rx_data,
	input wire logic o_tx_enable,
	input wire logic o_tx_sign,
	input wire logic o_tx_mag,
	input wire logic o_activating,
	input wire logic [2:0] o_major_state_code,
	input wire logic [3:0] o_activating_substate_status
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	sequence s_start;
		o_major_state_code == 3'h0 ##1 o_major_state_code == 3'h1;
	endsequence
	sequence s_sub_held;
		(o_activating_substate_status inside {[4'h1:4'h6]}) [*3];
	endsequence
	sequence s_first_held;
		(o_activating_substate_status == 4'h1) [*3];
	endsequence
	a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_major_read_back: assert property ($past(i_rd) && $past(i_addr) == dslas_pkg::ADDR_MAJOR
		|-> o_rdata[2:0] == $past(o_major_state_code))
		else $error("major state read back wrong");
	a_activating_exit: assert property (o_major_state_code == 3'h1
		|=> o_major_state_code inside {3'h1, 3'h2, 3'h4})
		else $error("illegal exit from activating");
	a_rx_forced_high: assert property (o_major_state_code <= 3'h1 |-> o_rx_data)
		else $error("received data not held high");
	a_sub_zero_idle: assert property (!o_activating |-> o_activating_substate_status == 4'h0)
		else $error("substate code outside activating");
	a_hw_start_edge: assert property (s_start |-> !i_master || !i_hw_mode
		|| ($past(i_link_up_request) && !$past(i_link_up_request, 2) && !$past(i_quiet)))
		else $error("hardware start without request edge");
	a_slave_energy_start: assert property (s_start |-> i_master || !$past(i_signal_absent))
		else $error("slave started without line energy");
	a_sub_step_one: assert property (o_activating && $past(o_activating)
		&& o_activating_substate_status != $past(o_activating_substate_status)
		|-> o_activating_substate_status == $past(o_activating_substate_status) + 4'h1)
		else $error("substate skipped");
	a_two_level_only: assert property (s_sub_held |-> !o_tx_mag)
		else $error("four-level symbol during two-level training");
	a_first_sub_tx: assert property (s_first_held |-> o_tx_enable == i_master)
		else $error("transmit enable wrong in first substate");
	a_rx_pass_through: assert property (o_major_state_code inside {3'h2, 3'h3}
		|-> o_rx_data == $past(i_rx_data))
		else $error("received data not passed in active state");
	a_silent_zero: assert property (!o_tx_enable |-> !o_tx_sign && !o_tx_mag)
		else $error("symbol bits set while transmitter silent");
endmodule
bind dslas_sequencer dslas_seq_checker chk_u (.*);
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic hw = 1'b0;
	logic mst = 1'b1;
	logic req = 1'b0;
	logic quiet = 1'b0;
	logic respond = 1'b0;
	logic fsw_ok = 1'b0;
	wire logic [7:0] rdata;
	wire logic [2:0] maj;
	wire logic [3:0] sub;
	wire logic ftick, stick, sslot, absent, fourl, frame_sync_word, rxd, rx_out, txe, txs, txm;
	wire logic act, deact, tmx;
	int err_total = 0;
	int checked = 0;
	dslas_sequencer dut_u (
		.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_hw_mode(hw), .i_master(mst),
		.i_link_up_request(req), .i_quiet(quiet), .i_frame_tick(ftick),
		.i_symbol_tick(stick), .i_sync_slot(sslot), .i_signal_absent(absent),
		.i_four_level_detect(fourl), .i_frame_sync_word(frame_sync_word), .i_tx_data_sign(rxd),
		.i_tx_data_mag(stick), .i_rx_data(rxd), .o_rx_data(rx_out), .o_tx_enable(txe),
		.o_tx_sign(txs), .o_tx_mag(txm), .o_activating(), .o_active(act), .o_deactivated(deact),
		.o_timer_expired(tmx), .o_major_state_code(maj), .o_activating_substate_status(sub)
	);
	dslas_remote_model far_u (
		.i_clk(i_clk), .i_srst(i_srst), .i_tx_enable(txe), .i_tx_mag(txm),
		.i_respond(respond), .i_fsw_ok(fsw_ok), .o_frame_tick(ftick),
		.o_symbol_tick(stick), .o_sync_slot(sslot), .o_signal_absent(absent),
		.o_four_level_detect(fourl), .o_frame_sync_word(frame_sync_word), .o_rx_data(rxd)
	);
	initial begin
		forever #12.5 i_clk = ~i_clk;
	end
	task automatic complete_run();
		if (err_total == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic do_reset();
		i_srst <= 1'b1;
		respond <= 1'b0;
		fsw_ok <= 1'b0;
		repeat (16) @(posedge i_clk);
		i_srst <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(name, rdata, exp);
	endtask
	// bounded wait for a major state and substate pair
	task automatic wait_for(input logic [2:0] m, input logic [3:0] s, input int n);
		int i;
		for (i = 0; i < n && !(maj === m && sub === s); i++) begin
			@(posedge i_clk);
			#1;
		end
		chk("state", {1'b0, maj, sub}, {1'b0, m, s});
		if (i == n) begin
			complete_run();
		end
	endtask
	initial begin
		do_reset();
		rd(dslas_pkg::ADDR_MAJOR, 8'h00, "major");
		rd(dslas_pkg::ADDR_CONFIG, 8'h07, "config");
		rd(4'h2, 8'h00, "unmapped");
		for (int m = 0; m < 8; m++) begin
			wr(dslas_pkg::ADDR_CONFIG, 8'(m));
			rd(dslas_pkg::ADDR_CONFIG, 8'(m), "mode");
		end
		// unframed master, far end late to answer
		wr(dslas_pkg::ADDR_CONFIG, 8'h10);
		wr(dslas_pkg::ADDR_CONTROL, 8'h01);
		wait_for(3'h1, 4'h1, 8);
		wr(dslas_pkg::ADDR_CONTROL, 8'h00);
		wait_for(3'h1, 4'h3, 400);
		repeat (80) @(posedge i_clk);
		rd(dslas_pkg::ADDR_SUBSTATE, 8'h03, "substate");
		respond <= 1'b1;
		wait_for(3'h1, 4'h4, 4);
		repeat (340) @(posedge i_clk);
		rd(dslas_pkg::ADDR_SUBSTATE, 8'h04, "substate");
		wait_for(3'h1, 4'h5, 40);
		wait_for(3'h2, 4'h0, 2000);
		rd(dslas_pkg::ADDR_MAJOR, 8'h02, "major");
		chk("active", {7'h00, act}, 8'h01);
		wait_for(3'h3, 4'h0, 14000);
		rd(dslas_pkg::ADDR_MAJOR, 8'h13, "major");
		// framed master needs two sync words in a row
		do_reset();
		wr(dslas_pkg::ADDR_CONFIG, 8'h17);
		wr(dslas_pkg::ADDR_CONTROL, 8'h01);
		respond <= 1'b1;
		wait_for(3'h1, 4'h8, 2000);
		repeat (40) @(posedge i_clk);
		rd(dslas_pkg::ADDR_SUBSTATE, 8'h08, "substate");
		fsw_ok <= 1'b1;
		wait_for(3'h2, 4'h0, 40);
		// no answer at all: timeout aborts the attempt
		do_reset();
		wr(dslas_pkg::ADDR_CONFIG, 8'h10);
		wr(dslas_pkg::ADDR_CONTROL, 8'h01);
		wr(dslas_pkg::ADDR_CONTROL, 8'h00);
		wait_for(3'h4, 4'h0, 14000);
		chk("abort flags", {6'h00, deact, tmx}, 8'h03);
		rd(dslas_pkg::ADDR_MAJOR, 8'h14, "major");
		wait_for(3'h0, 4'h0, 8);
		rd(dslas_pkg::ADDR_MAJOR, 8'h10, "major");
		// pin control: silence blocks, only a fresh rise starts
		hw <= 1'b1;
		quiet <= 1'b1;
		do_reset();
		repeat (2) @(posedge i_clk);
		req <= 1'b1;
		repeat (20) @(posedge i_clk);
		rd(dslas_pkg::ADDR_MAJOR, 8'h00, "major");
		quiet <= 1'b0;
		repeat (20) @(posedge i_clk);
		rd(dslas_pkg::ADDR_MAJOR, 8'h00, "major");
		req <= 1'b0;
		repeat (2) @(posedge i_clk);
		req <= 1'b1;
		wait_for(3'h1, 4'h1, 8);
		// slave ignores the request and follows line energy
		req <= 1'b0;
		hw <= 1'b0;
		mst <= 1'b0;
		do_reset();
		wr(dslas_pkg::ADDR_CONTROL, 8'h01);
		repeat (20) @(posedge i_clk);
		rd(dslas_pkg::ADDR_MAJOR, 8'h00, "major");
		respond <= 1'b1;
		wait_for(3'h1, 4'h1, 8);
		wait_for(3'h1, 4'h6, 1200);
		repeat (80) @(posedge i_clk);
		rd(dslas_pkg::ADDR_SUBSTATE, 8'h06, "substate");
		respond <= 1'b0;
		wait_for(3'h0, 4'h0, 20);
		complete_run();
	end
endmodule
`default_nettype wire
